/* src/dsc_top.sv */
// Serial command unit: receives 16-bit frames and drives tap, terminals and pump.
// Assumes CS_N, SCLK and DIN are asynchronous pins, SCLK much slower than CLOCK.
`timescale 1ns/1ps

// Behaviour
// - Top-end max shutdown: tap 0xFF, top open
// - Bottom hold shutdown: bottom open, tap stored
// - Bottom min shutdown: tap 0x00, bottom open
// - Bottom centre shutdown: tap 0x80, bottom open
// - Bottom max shutdown: tap 0xFF, bottom open
// - Tap-open shutdown: tap terminal open, stored
// - Wiper writes ignored during any shutdown
// - Clearing shutdown reconnects, restores, unlocks writes
// - Reset command: wiper 0x80, pump on, run
// - Shutdown commands keep pump state
// - Pump enable command; enabled after power-on
// - Pump disable command enters low power
// - Shift on falling edges, act after all
// - Leave-shutdown restores everything, pump untouched
// - Power-on wiper register is midscale
module dsc_top
  import dsc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic DIN,
  output dsc_pkg::dsc_pot_s POT,
  output logic PUMP_EN,
  output logic LOW_POWER
);
  import dsc_pkg::*;

  dsc_state_s s_q;
  dsc_state_s s_d;
  logic fall;
  logic exec;
  logic [15:0] word;
  logic [7:0] cmd;
  logic [7:0] dat;

  // Falling serial clock inside a selected frame.
  assign fall = s_q.sck_p & ~s_q.sck2 & ~s_q.cs2;
  assign exec = fall && (s_q.cnt == LAST_BIT);
  assign word = {s_q.shift[14:0], s_q.din2};
  assign cmd = word[15:8];
  assign dat = word[7:0];

  always_comb begin
    s_d = s_q;
    s_d.cs1 = CS_N;
    s_d.cs2 = s_q.cs1;
    s_d.sck1 = SCLK;
    s_d.sck2 = s_q.sck1;
    s_d.sck_p = s_q.sck2;
    s_d.din1 = DIN;
    s_d.din2 = s_q.din1;
    if (s_q.cs2) begin
      s_d.cnt = 5'h00;
    end else if (fall && s_q.cnt != FULL_CNT) begin
      s_d.shift = word;
      s_d.cnt = s_q.cnt + 5'h01;
    end
    if (exec) begin
      case (cmd)
        CMD_WIPER_WRITE: begin
          if (s_q.mode == DSC_RUN) begin
            s_d.pot.wiper = dat;
          end
        end
        CMD_LEAVE_SHUTDOWN: s_d.mode = DSC_RUN;
        CMD_OPEN_TOP_END_FORCE_MAX: s_d.mode = DSC_TOP_MAX;
        CMD_OPEN_BOTTOM_END_HOLD_STORED: s_d.mode = DSC_BOT_HOLD;
        CMD_OPEN_BOTTOM_END_FORCE_MIN: s_d.mode = DSC_BOT_MIN;
        CMD_OPEN_BOTTOM_END_FORCE_CENTRE: s_d.mode = DSC_BOT_CENTRE;
        CMD_OPEN_BOTTOM_END_FORCE_MAX: s_d.mode = DSC_BOT_MAX;
        CMD_OPEN_TAP_TERMINAL: s_d.mode = DSC_TAP_OPEN;
        CMD_PUMP_ENABLE: s_d.pump = 1'b1;
        CMD_PUMP_DISABLE: s_d.pump = 1'b0;
        CMD_RESET: begin
          s_d.pot.wiper = WIPER_RESET;
          s_d.pump = PUMP_RESET;
          s_d.mode = DSC_RUN;
        end
        default: s_d.mode = s_q.mode;
      endcase
    end
    s_d.pot.open_top = (s_d.mode == DSC_TOP_MAX);
    s_d.pot.open_bottom = (s_d.mode == DSC_BOT_HOLD) || (s_d.mode == DSC_BOT_MIN)
      || (s_d.mode == DSC_BOT_CENTRE) || (s_d.mode == DSC_BOT_MAX);
    s_d.pot.open_tap = (s_d.mode == DSC_TAP_OPEN);
    case (s_d.mode)
      DSC_TOP_MAX: s_d.pot.tap = TAP_MAX;
      DSC_BOT_MIN: s_d.pot.tap = TAP_MIN;
      DSC_BOT_CENTRE: s_d.pot.tap = TAP_CENTRE;
      DSC_BOT_MAX: s_d.pot.tap = TAP_MAX;
      default: s_d.pot.tap = s_d.pot.wiper;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      s_q <= '0;
      s_q.cs1 <= 1'b1;
      s_q.cs2 <= 1'b1;
      s_q.mode <= DSC_RUN;
      s_q.pump <= PUMP_RESET;
      s_q.pot.wiper <= WIPER_RESET;
      s_q.pot.tap <= WIPER_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign POT = s_q.pot;
  assign PUMP_EN = s_q.pump;
  assign LOW_POWER = ~s_q.pump;

  default clocking dcb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  sequence seq_cmd(logic [7:0] c);
    exec && (cmd == c);
  endsequence

  sequence seq_shut;
    exec && (cmd[7:4] == 4'h8 || cmd == CMD_OPEN_TOP_END_FORCE_MAX) && cmd != CMD_LEAVE_SHUTDOWN;
  endsequence

  sequence seq_write_run;
    exec && (cmd == CMD_WIPER_WRITE) && (s_q.mode == DSC_RUN);
  endsequence

  sequence seq_write_locked;
    exec && (cmd == CMD_WIPER_WRITE) && (s_q.mode != DSC_RUN);
  endsequence

  sequence seq_bit_in;
    fall && (s_q.cnt != FULL_CNT);
  endsequence

  chk_top_max_tap: assert property (seq_cmd(CMD_OPEN_TOP_END_FORCE_MAX) |=>
    POT.tap == TAP_MAX && POT.open_top && POT.wiper == $past(POT.wiper))
    else $error("top max shutdown wrong");
  chk_bot_hold: assert property (seq_cmd(CMD_OPEN_BOTTOM_END_HOLD_STORED) |=>
    POT.open_bottom && !POT.open_top && POT.tap == POT.wiper && $stable(POT.wiper))
    else $error("bottom hold shutdown wrong");
  chk_bot_min: assert property (seq_cmd(CMD_OPEN_BOTTOM_END_FORCE_MIN) |=>
    POT.tap == TAP_MIN && POT.open_bottom && $stable(POT.wiper))
    else $error("bottom min shutdown wrong");
  chk_bot_centre: assert property (seq_cmd(CMD_OPEN_BOTTOM_END_FORCE_CENTRE) |=>
    POT.tap == TAP_CENTRE && POT.open_bottom && $stable(POT.wiper))
    else $error("bottom centre shutdown wrong");
  chk_bot_max: assert property (seq_cmd(CMD_OPEN_BOTTOM_END_FORCE_MAX) |=>
    POT.tap == TAP_MAX && POT.open_bottom && $stable(POT.wiper))
    else $error("bottom max shutdown wrong");
  chk_tap_open: assert property (seq_cmd(CMD_OPEN_TAP_TERMINAL) |=>
    POT.open_tap && !POT.open_bottom && POT.tap == POT.wiper && $stable(POT.wiper))
    else $error("tap open shutdown wrong");

  chk_write_locked: assert property (seq_write_locked |=>
    $stable(POT.wiper) && $stable(POT.tap))
    else $error("wiper written during shutdown");
  chk_write_taken: assert property (seq_write_run |=>
    POT.wiper == $past(dat) && POT.tap == $past(dat))
    else $error("wiper write lost");
  chk_run_follows: assert property (s_q.mode == DSC_RUN |->
    POT.tap == POT.wiper && !POT.open_top && !POT.open_bottom && !POT.open_tap)
    else $error("running tap off stored wiper");
  chk_leave_restore: assert property (seq_cmd(CMD_LEAVE_SHUTDOWN) |=>
    !POT.open_top && !POT.open_bottom && !POT.open_tap && POT.tap == POT.wiper && $stable(PUMP_EN))
    else $error("leaving shutdown wrong");
  chk_reset_cmd: assert property (seq_cmd(CMD_RESET) |=>
    POT.wiper == WIPER_RESET && POT.tap == WIPER_RESET && PUMP_EN && !POT.open_top && !POT.open_bottom)
    else $error("reset command wrong");

  chk_shut_pump: assert property (seq_shut |=>
    $stable(PUMP_EN))
    else $error("shutdown moved pump");
  chk_pump_source: assert property (!$stable(PUMP_EN) |->
    $past(SYS_RST) || ($past(exec) && ($past(cmd) == CMD_PUMP_ENABLE
    || $past(cmd) == CMD_PUMP_DISABLE || $past(cmd) == CMD_RESET)))
    else $error("pump moved without a pump command");
  chk_pump_on: assert property (seq_cmd(CMD_PUMP_ENABLE) |=>
    PUMP_EN && !LOW_POWER)
    else $error("pump on failed");
  chk_pump_off: assert property (seq_cmd(CMD_PUMP_DISABLE) |=>
    !PUMP_EN && LOW_POWER)
    else $error("pump off failed");
  chk_low_power: assert property (LOW_POWER == !PUMP_EN)
    else $error("low power not inverse of pump");

  chk_power_on: assert property (@(posedge CLOCK) $fell(SYS_RST) |->
    POT.wiper == WIPER_RESET && PUMP_EN)
    else $error("power-on state wrong");
  chk_wiper_source: assert property (!$stable(POT.wiper) |->
    $past(SYS_RST) || ($past(exec) && ($past(cmd) == CMD_RESET
    || ($past(cmd) == CMD_WIPER_WRITE && $past(s_q.mode) == DSC_RUN))))
    else $error("wiper moved without a write");
  chk_idle_hold: assert property (!exec |=>
    $stable(POT) && $stable(PUMP_EN))
    else $error("state moved without frame");
  chk_frame_len: assert property (exec |->
    s_q.cnt == LAST_BIT && !s_q.cs2)
    else $error("frame acted early");
  chk_shift_in: assert property (seq_bit_in |=>
    s_q.shift == {$past(s_q.shift[14:0]), $past(s_q.din2)})
    else $error("serial bit not shifted in");
  chk_cut_clears: assert property (s_q.cs2 |=>
    s_q.cnt == 5'h00)
    else $error("cut frame count kept");
  chk_count_cap: assert property (s_q.cnt <= FULL_CNT)
    else $error("bit count ran past frame");
  chk_one_open: assert property ($onehot0({POT.open_top, POT.open_bottom, POT.open_tap}))
    else $error("several terminals open");

endmodule

/* include/dsc_pkg.sv */
// Package for the shutdown command unit of a 256-tap volatile potentiometer.
// Assumes one design file imports it whole and uses its types on its ports.
package dsc_pkg;

  localparam int FRAME_BITS = 16;
  localparam logic [4:0] LAST_BIT = 5'h0F;
  localparam logic [4:0] FULL_CNT = 5'h10;

  localparam logic [7:0] TAP_MIN = 8'h00;
  localparam logic [7:0] TAP_CENTRE = 8'h80;
  localparam logic [7:0] TAP_MAX = 8'hFF;
  localparam logic [7:0] WIPER_RESET = 8'h80;
  localparam logic PUMP_RESET = 1'b1;

  localparam logic [7:0] CMD_WIPER_WRITE = 8'h00;
  localparam logic [7:0] CMD_LEAVE_SHUTDOWN = 8'h80;
  localparam logic [7:0] CMD_OPEN_TOP_END_FORCE_MAX = 8'h93;
  localparam logic [7:0] CMD_OPEN_BOTTOM_END_HOLD_STORED = 8'h88;
  localparam logic [7:0] CMD_OPEN_BOTTOM_END_FORCE_MIN = 8'h89;
  localparam logic [7:0] CMD_OPEN_BOTTOM_END_FORCE_CENTRE = 8'h8A;
  localparam logic [7:0] CMD_OPEN_BOTTOM_END_FORCE_MAX = 8'h8B;
  localparam logic [7:0] CMD_OPEN_TAP_TERMINAL = 8'h8C;
  localparam logic [7:0] CMD_PUMP_DISABLE = 8'hA0;
  localparam logic [7:0] CMD_PUMP_ENABLE = 8'hA1;
  localparam logic [7:0] CMD_RESET = 8'hC0;

  typedef enum logic [2:0] {
    DSC_RUN = 3'h0,
    DSC_TOP_MAX = 3'h1,
    DSC_BOT_HOLD = 3'h3,
    DSC_BOT_MIN = 3'h2,
    DSC_BOT_CENTRE = 3'h6,
    DSC_BOT_MAX = 3'h7,
    DSC_TAP_OPEN = 3'h5
  } dsc_mode_e;

  typedef struct packed {
    logic [7:0] tap;
    logic [7:0] wiper;
    logic open_top;
    logic open_bottom;
    logic open_tap;
  } dsc_pot_s;

  typedef struct packed {
    logic cs1;
    logic cs2;
    logic sck1;
    logic sck2;
    logic sck_p;
    logic din1;
    logic din2;
    logic [15:0] shift;
    logic [4:0] cnt;
    dsc_mode_e mode;
    logic pump;
    dsc_pot_s pot;
  } dsc_state_s;

endpackage

/* verification/dsc_host.sv */
// Host model that writes frames on the serial link.
// Assumes CLOCK is the bench clock; SCLK runs at 32 CLOCK periods (160 ns).
`timescale 1ns/1ps
module dsc_host (
  input wire logic CLOCK,
  output logic CS_N,
  output logic SCLK,
  output logic DIN
);
  initial begin
    CS_N = 1'b1;
    SCLK = 1'b1;
    DIN = 1'b0;
  end
  // Sends the top n bits of w, MSB first; n below 16 cuts the frame short.
  task automatic send(input logic [15:0] w, input int n);
    @(posedge CLOCK);
    CS_N <= 1'b0;
    repeat (8) @(posedge CLOCK);
    for (int i = 15; i > 15 - n; i--) begin
      SCLK <= 1'b1;
      DIN <= w[i];
      repeat (16) @(posedge CLOCK);
      SCLK <= 1'b0;
      repeat (16) @(posedge CLOCK);
    end
    SCLK <= 1'b1;
    repeat (16) @(posedge CLOCK);
    CS_N <= 1'b1;
    DIN <= ~DIN;
    repeat (16) @(posedge CLOCK);
  endtask
endmodule

/* verification/testbench.sv */
// Self-checking bench for the shutdown command unit.
// Assumes the host model drives the serial pins.
`timescale 1ns/1ps
module testbench;
  logic clock;
  logic sys_rst;
  logic cs_n;
  logic sclk;
  logic din;
  dsc_pkg::dsc_pot_s pot;
  logic pump_en;
  logic low_power;
  int err_count = 0;
  int checked = 0;
  logic [18:0] sd_row [6] = '{{8'h93, 8'hFF, 3'h4}, {8'h88, 8'h3C, 3'h2}, {8'h89, 8'h00, 3'h2},
    {8'h8A, 8'h80, 3'h2}, {8'h8B, 8'hFF, 3'h2}, {8'h8C, 8'h3C, 3'h1}};

  dsc_host host (.CLOCK(clock), .CS_N(cs_n), .SCLK(sclk), .DIN(din));
  dsc_top dut (.CLOCK(clock), .SYS_RST(sys_rst), .CS_N(cs_n), .SCLK(sclk), .DIN(din),
    .POT(pot), .PUMP_EN(pump_en), .LOW_POWER(low_power));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic complete_run();
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Compares tap, wiper, the three opens and the pump outputs together.
  task automatic expect_st(input logic [7:0] tap, input logic [7:0] wip, input logic [2:0] op, input logic pmp);
    check({pot, pump_en, low_power}, {tap, wip, op, pmp, ~pmp});
  endtask

  task automatic cmd(input logic [7:0] c, input logic [7:0] d);
    host.send({c, d}, 16);
  endtask

  initial begin
    sys_rst = 1'b1;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clock);
    expect_st(8'h80, 8'h80, 3'h0, 1'b1);
    cmd(8'h00, 8'h3C);
    expect_st(8'h3C, 8'h3C, 3'h0, 1'b1);
    cmd(8'hA0, 8'h00);
    expect_st(8'h3C, 8'h3C, 3'h0, 1'b0);
    for (int k = 0; k < 6; k++) begin
      cmd(sd_row[k][18:11], 8'h00);
      expect_st(sd_row[k][10:3], 8'h3C, sd_row[k][2:0], 1'b0);
      cmd(8'h00, 8'h55);
      expect_st(sd_row[k][10:3], 8'h3C, sd_row[k][2:0], 1'b0);
      cmd(8'h80, 8'h00);
      expect_st(8'h3C, 8'h3C, 3'h0, 1'b0);
    end
    cmd(8'h00, 8'hC3);
    expect_st(8'hC3, 8'hC3, 3'h0, 1'b0);
    host.send(16'hA100, 10);
    expect_st(8'hC3, 8'hC3, 3'h0, 1'b0);
    cmd(8'hA1, 8'h00);
    expect_st(8'hC3, 8'hC3, 3'h0, 1'b1);
    cmd(8'h8B, 8'h00);
    expect_st(8'hFF, 8'hC3, 3'h2, 1'b1);
    cmd(8'hA0, 8'h00);
    expect_st(8'hFF, 8'hC3, 3'h2, 1'b0);
    cmd(8'hC0, 8'h00);
    expect_st(8'h80, 8'h80, 3'h0, 1'b1);
    complete_run();
  end
endmodule
